// ==== verilog/errs_seq.sv ====
// Operation
// - Enables low one cycle before reset
// - Enables low two cycles after release
// - Global reset acts asynchronously
// - Steady clocks before reset if enabled
// - Release meets synchronous setup time
// - Preloaded memory: global reset off
// - FIFO: strobes alone move pointers and reads; word writes also need clk_en
// - Rewind gated by fetch, full by both
// - FIFO resets act asynchronously
// - Synchronous reset needs no sequencing
// - Same sequencing for RAM, ROM, FIFO
`timescale 1ns/1ps
`default_nettype none
`include "errs_cfg.svh"
module errs_seq (
    input  wire logic                mclk,
    input  wire logic                resetn,
    input  wire errs_pkg::errs_mode_t mode,
    input  wire logic                preloaded,
    input  wire logic                use_sync,
    input  wire logic                req_global,
    input  wire logic                req_full,
    input  wire logic                req_rewind,
    input  wire logic                keep_enabled,
    input  wire logic                user_en,
    input  wire logic                user_wr,
    input  wire logic                user_rd,
    input  wire logic [`ERRS_AW-1:0] user_addr,
    input  wire logic [`ERRS_DW-1:0] user_wdata,
    output logic [`ERRS_DW-1:0]      user_rdata,
    output logic                     user_full,
    output logic                     user_empty,
    output logic                     busy,
    output logic                     done,
    errs_if.user                     bus
);
    import errs_pkg::*;
    errs_state_t            state_q;
    logic [`ERRS_CNT_W-1:0] cnt_q;
    logic                   kind_g_q;
    logic                   kind_f_q;
    logic                   kind_r_q;
    logic                   keep_q;
    logic                   done_q;
    logic                   en_ok;
    logic                   strobe_ok;
    logic                   cnt_end;
    logic                   rst_on;
    logic                   start;
    // Phase lengths in clock cycles
    localparam logic [`ERRS_CNT_W-1:0] STEADY = `ERRS_CNT_W'(`ERRS_STEADY_CYC);
    localparam logic [`ERRS_CNT_W-1:0] GUARD  = `ERRS_CNT_W'(`ERRS_GUARD_CYC);
    localparam logic [`ERRS_CNT_W-1:0] HOLD   = `ERRS_CNT_W'(`ERRS_HOLD_CYC);

    // Requests raised while busy are dropped, not queued
    // synchronous reset bypasses sequencing
    assign start = (req_global | req_full | req_rewind) & ~use_sync;

    // Limitation: resetn mid-sequence drops reset and restores enables together
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_q <= ERRS_IDLE;
        end else begin
            case (state_q)
                ERRS_IDLE: begin
                    if (start) begin
                        state_q <= ERRS_QUIESCE;
                    end
                end
                ERRS_QUIESCE: begin
                    if (cnt_end) begin
                        state_q <= ERRS_ASSERT;
                    end
                end
                ERRS_ASSERT: begin
                    if (cnt_end) begin
                        state_q <= ERRS_RELEASE;
                    end
                end
                ERRS_RELEASE: begin
                    if (cnt_end) begin
                        state_q <= ERRS_DONE;
                    end
                end
                ERRS_DONE: begin
                    state_q <= ERRS_IDLE;
                end
                default: begin
                    state_q <= ERRS_IDLE;
                end
            endcase
        end
    end

    // Phase length, reloaded as the quiesce and assert phases end
    assign cnt_end = (cnt_q <= `ERRS_CNT_W'(1));

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else begin
            case (state_q)
                ERRS_IDLE: begin
                    if (start) begin
                        // wait steady clocks if enables kept
                        cnt_q <= keep_enabled ? STEADY : GUARD;
                    end
                end
                ERRS_QUIESCE: begin
                    cnt_q <= cnt_end ? HOLD : cnt_q - 1'b1;
                end
                ERRS_ASSERT: begin
                    // release two full periods before enables return (release phase, then done)
                    cnt_q <= cnt_end ? (keep_q ? STEADY : GUARD) : cnt_q - 1'b1;
                end
                ERRS_RELEASE: begin
                    if (!cnt_end) begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: begin
                    cnt_q <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            kind_g_q <= 1'b0;
            kind_f_q <= 1'b0;
            kind_r_q <= 1'b0;
            keep_q   <= 1'b0;
        end else if (state_q == ERRS_IDLE && start) begin
            kind_g_q <= req_global;
            kind_f_q <= req_full;
            kind_r_q <= req_rewind;
            keep_q   <= keep_enabled;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == ERRS_DONE);
        end
    end

    // same gating whatever the mode
    // Keep path drops the strobes only while reset is on; enables stay low for the whole sequence
    always_comb begin
        en_ok     = 1'b0;
        strobe_ok = 1'b0;
        case (state_q)
            ERRS_IDLE: begin
                en_ok     = 1'b1;
                strobe_ok = 1'b1;
            end
            ERRS_QUIESCE, ERRS_RELEASE, ERRS_DONE: begin
                en_ok     = 1'b0;
                strobe_ok = keep_q;
            end
            ERRS_ASSERT: begin
                en_ok     = 1'b0;
                strobe_ok = 1'b0;
            end
            default: begin
                en_ok     = 1'b0;
                strobe_ok = 1'b0;
            end
        endcase
    end

    assign rst_on = (state_q == ERRS_ASSERT);
    assign busy   = (state_q != ERRS_IDLE);
    assign done   = done_q;

    // preloaded contents keep global reset disabled
    assign bus.gsr_enable       = ~preloaded;
    assign bus.global_set_reset = rst_on & kind_g_q & ~preloaded;
    assign bus.fifo_reset       = rst_on & kind_f_q;
    assign bus.pointer_rewind   = rst_on & kind_r_q;
    // Sync path: pointers and read data clear at the memory's next edge
    assign bus.sync_reset       = use_sync & (req_global | req_full | req_rewind);
    assign bus.mode             = mode;

    assign bus.clk_en           = user_en & en_ok;
    // strobes gated like enables in every mode, except while enables are kept
    // rewind vs fetch, full vs both
    assign bus.write_strobe     = user_wr & strobe_ok;
    assign bus.fetch_strobe     = user_rd & strobe_ok;

    assign bus.addr             = user_addr;
    assign bus.wdata            = user_wdata;

    assign user_rdata           = bus.rdata;
    assign user_full            = bus.full;
    assign user_empty           = bus.empty;
endmodule
`default_nettype wire

// ==== verilog/errs_cfg.svh ====
`ifndef ERRS_CFG_SVH
`define ERRS_CFG_SVH
// Memory clock period and the quiet time before touching reset
`define ERRS_CLK_PERIOD_NS 10
`define ERRS_FMAX_MHZ 100
`define ERRS_STEADY_NS (1000 / `ERRS_FMAX_MHZ)
`define ERRS_STEADY_RAW ((`ERRS_STEADY_NS + `ERRS_CLK_PERIOD_NS - 1) / `ERRS_CLK_PERIOD_NS)
`define ERRS_STEADY_CYC (`ERRS_STEADY_RAW < 1 ? 1 : `ERRS_STEADY_RAW)
// Guard cycles with enables low around reset
`define ERRS_GUARD_CYC 1
// Cycles the reset pulse is held asserted
`define ERRS_HOLD_CYC 2
`define ERRS_CNT_W 4
`define ERRS_DEPTH 16
`define ERRS_AW 4
`define ERRS_DW 8
// Mode codes
`define ERRS_MODE_RAM 2'h0
`define ERRS_MODE_ROM 2'h1
`define ERRS_MODE_FIFO 2'h2
`endif

// ==== verilog/errs_pkg.sv ====
`default_nettype none
`include "errs_cfg.svh"
package errs_pkg;
    typedef enum logic [1:0] {
        ERRS_RAM  = `ERRS_MODE_RAM,
        ERRS_ROM  = `ERRS_MODE_ROM,
        ERRS_FIFO = `ERRS_MODE_FIFO
    } errs_mode_t;
    typedef enum logic [2:0] {
        ERRS_IDLE    = 3'h0,
        ERRS_QUIESCE = 3'h1,
        ERRS_ASSERT  = 3'h2,
        ERRS_RELEASE = 3'h3,
        ERRS_DONE    = 3'h4
    } errs_state_t;
endpackage
`default_nettype wire

// ==== verilog/errs_if.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "errs_cfg.svh"
interface errs_if;
    import errs_pkg::*;
    logic                   clk_en;
    logic                   write_strobe;
    logic                   fetch_strobe;
    logic                   global_set_reset;
    logic                   fifo_reset;
    logic                   pointer_rewind;
    logic                   sync_reset;
    logic                   gsr_enable;
    logic [`ERRS_AW-1:0]    addr;
    logic [`ERRS_DW-1:0]    wdata;
    logic [`ERRS_DW-1:0]    rdata;
    logic                   full;
    logic                   empty;
    errs_mode_t             mode;
    modport ram (input clk_en, write_strobe, fetch_strobe, global_set_reset, fifo_reset,
                 pointer_rewind, sync_reset, gsr_enable, addr, wdata, mode,
                 output rdata, full, empty);
    modport user (output clk_en, write_strobe, fetch_strobe, global_set_reset, fifo_reset,
                  pointer_rewind, sync_reset, gsr_enable, addr, wdata, mode,
                  input rdata, full, empty);
endinterface
`default_nettype wire

// ==== verilog/errs_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "errs_cfg.svh"
module errs_mem (
    input  wire logic  mclk,
    errs_if.ram        bus
);
    import errs_pkg::*;
    logic [`ERRS_DW-1:0] mem_q [`ERRS_DEPTH];
    logic [`ERRS_AW:0]   wp_q;
    logic [`ERRS_AW:0]   rp_q;
    logic                arst;
    logic                prst;
    logic                gsr_act;
    assign gsr_act = bus.global_set_reset & (bus.gsr_enable | (bus.mode == ERRS_FIFO));
    assign arst = gsr_act | bus.fifo_reset;
    assign prst = arst | bus.pointer_rewind;
    genvar gi;
    generate
        for (gi = 0; gi < `ERRS_DEPTH; gi++) begin : g_word
            always_ff @(posedge mclk or posedge gsr_act) begin
                if (gsr_act) begin
                    mem_q[gi] <= '0;
                end else if (bus.clk_en && bus.write_strobe && bus.mode != ERRS_ROM) begin
                    if (bus.mode == ERRS_FIFO ? wp_q[`ERRS_AW-1:0] == gi : bus.addr == gi) begin
                        mem_q[gi] <= bus.wdata;
                    end
                end
            end
        end
    endgenerate
    always_ff @(posedge mclk or posedge arst) begin
        if (arst) begin
            wp_q <= '0;
        end else if (bus.sync_reset) begin
            wp_q <= '0;
        end else if (bus.mode == ERRS_FIFO && bus.write_strobe && !bus.full) begin
            wp_q <= wp_q + 1'b1;
        end
    end
    always_ff @(posedge mclk or posedge prst) begin
        if (prst) begin
            rp_q <= '0;
        end else if (bus.sync_reset) begin
            rp_q <= '0;
        end else if (bus.mode == ERRS_FIFO && bus.fetch_strobe && !bus.empty) begin
            rp_q <= rp_q + 1'b1;
        end
    end
    always_ff @(posedge mclk or posedge gsr_act) begin
        if (gsr_act) begin
            bus.rdata <= '0;
        end else if (bus.sync_reset) begin
            bus.rdata <= '0;
        end else if (bus.mode == ERRS_FIFO) begin
            if (bus.fetch_strobe && !bus.empty) begin
                bus.rdata <= mem_q[rp_q[`ERRS_AW-1:0]];
            end
        end else if (bus.clk_en && bus.fetch_strobe) begin
            bus.rdata <= mem_q[bus.addr];
        end
    end
    assign bus.empty = (wp_q == rp_q);
    assign bus.full  = (wp_q[`ERRS_AW-1:0] == rp_q[`ERRS_AW-1:0]) &&
                       (wp_q[`ERRS_AW] != rp_q[`ERRS_AW]);
endmodule
`default_nettype wire

// ==== testbench/errs_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "errs_cfg.svh"
module errs_assertions (
    input wire logic                mclk,
    input wire logic                resetn,
    input wire logic                clk_en,
    input wire logic                write_strobe,
    input wire logic                fetch_strobe,
    input wire logic                global_set_reset,
    input wire logic                fifo_reset,
    input wire logic                pointer_rewind,
    input wire logic                sync_reset,
    input wire logic                gsr_enable,
    input wire logic [`ERRS_DW-1:0] rdata,
    input wire logic                full,
    input wire logic                empty,
    input wire errs_pkg::errs_mode_t mode
);
    import errs_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    wire rst_any = global_set_reset | fifo_reset | pointer_rewind;

    chk_quiet_before: assert property ($rose(rst_any) |-> !$past(clk_en))
        else $error("enable high just before reset");
    chk_quiet_after: assert property ($fell(rst_any) |-> !clk_en)
        else $error("enable restored with reset release");
    chk_quiet_during: assert property (rst_any |-> !clk_en)
        else $error("enable high during reset");
    chk_hold_two: assert property ($rose(rst_any) |-> rst_any ##1 rst_any ##1 !rst_any)
        else $error("reset pulse not two cycles");
    chk_strobes_gated: assert property (rst_any |-> !write_strobe && !fetch_strobe)
        else $error("strobe active during reset");
    chk_fifo_clear: assert property (fifo_reset && mode == ERRS_FIFO |-> empty && !full)
        else $error("fifo flags not cleared by reset");
    chk_gsr_clears: assert property (global_set_reset && gsr_enable |-> rdata == 8'h00)
        else $error("read data not cleared by global reset");
    chk_sync_direct: assert property (sync_reset |-> !rst_any)
        else $error("sync reset used the sequenced path");
    chk_sync_clears: assert property (sync_reset && mode == ERRS_FIFO |=> empty)
        else $error("sync reset did not empty fifo");

    cover property ($rose(fifo_reset));
    cover property ($rose(pointer_rewind));
    cover property ($rose(global_set_reset));
    cover property ($rose(sync_reset));
endmodule
`default_nettype wire

// ==== testbench/tb_embedded_ram_reset_sequencing.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_embedded_ram_reset_sequencing;
    import errs_pkg::*;
    typedef struct packed {errs_mode_t m; logic g, f, r, k, p; logic [7:0] hi;} errs_row_t;
    localparam errs_row_t ROWS [6] = '{
        '{ERRS_RAM, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h02},
        '{ERRS_ROM, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h02},
        '{ERRS_FIFO, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h02},
        '{ERRS_FIFO, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h02},
        '{ERRS_RAM, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 8'h02},
        '{ERRS_RAM, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'h00}};
    logic mclk = 0, resetn = 0, preloaded = 0, use_sync = 0, keep_enabled = 0;
    logic req_global = 0, req_full = 0, req_rewind = 0, user_en = 1, user_wr = 0, user_rd = 0;
    errs_mode_t mode = ERRS_RAM;
    logic [7:0] user_rdata;
    logic       user_full, user_empty, busy, done;
    int         fail_count = 0, checked = 0, n, hi;
    errs_if errs_if_i ();
    errs_mem errs_mem_i (.mclk(mclk), .bus(errs_if_i));
    errs_seq errs_seq_i (.mclk(mclk), .resetn(resetn), .mode(mode), .preloaded(preloaded),
        .use_sync(use_sync), .req_global(req_global), .req_full(req_full),
        .req_rewind(req_rewind), .keep_enabled(keep_enabled), .user_en(user_en),
        .user_wr(user_wr), .user_rd(user_rd), .user_addr(4'h3), .user_wdata(8'h5a),
        .user_rdata(user_rdata), .user_full(user_full), .user_empty(user_empty),
        .busy(busy), .done(done), .bus(errs_if_i));
    errs_assertions errs_assertions_i (.mclk(mclk), .resetn(resetn),
        .clk_en(errs_if_i.clk_en), .write_strobe(errs_if_i.write_strobe),
        .fetch_strobe(errs_if_i.fetch_strobe), .global_set_reset(errs_if_i.global_set_reset),
        .fifo_reset(errs_if_i.fifo_reset), .pointer_rewind(errs_if_i.pointer_rewind),
        .sync_reset(errs_if_i.sync_reset), .gsr_enable(errs_if_i.gsr_enable),
        .rdata(errs_if_i.rdata), .full(errs_if_i.full), .empty(errs_if_i.empty),
        .mode(errs_if_i.mode));
    initial begin
        forever #5 mclk = ~mclk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Counts edges to done; reset cycles seen; a live enable while busy spoils the count
    task automatic run(input errs_row_t r);
        n = 0;
        hi = 0;
        mode = r.m;
        {req_global, req_full, req_rewind, keep_enabled, preloaded} = {r.g, r.f, r.r, r.k, r.p};
        do begin
            @(posedge mclk);
            #1;
            n++;
            {req_global, req_full, req_rewind} = 3'h0;
            if ((errs_if_i.global_set_reset & (errs_if_i.gsr_enable | (mode == ERRS_FIFO)))
                | errs_if_i.fifo_reset | errs_if_i.pointer_rewind)
                hi++;
            if (busy === 1'b1 && errs_if_i.clk_en !== 1'b0)
                hi += 100;
        end while (done !== 1'b1 && n < 20);
    endtask
    task automatic fill(input int k);
        mode = ERRS_FIFO;
        user_wr = 1;
        repeat (k) @(posedge mclk);
        #1;
        user_wr = 0;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        #1;
        resetn = 1;
        check({busy, done}, 2'h0);
        foreach (ROWS[i]) begin
            run(ROWS[i]);
            check(hi[7:0], ROWS[i].hi);
            if (ROWS[i].p == 1'b0) check(n[7:0], 8'h06);
            check(errs_if_i.clk_en, 1'b1);
            @(posedge mclk);
            #1;
            check({busy, done}, 2'h0);
        end
        preloaded = 0;
        fill(16);
        check({user_empty, user_full}, 2'h1);
        run(ROWS[2]);
        check({user_empty, user_full}, 2'h2);
        fill(1);
        use_sync = 1;
        req_full = 1;
        @(posedge mclk);
        #1;
        check({busy, errs_if_i.sync_reset, user_empty}, 3'h3);
        {use_sync, req_full} = 2'h0;
        fill(1);
        user_rd = 1;
        @(posedge mclk);
        #1;
        user_rd = 0;
        check(user_rdata, 8'h5a);
        run(ROWS[0]);
        check(user_rdata, 8'h00);
        test_done();
    end
    initial begin
        #20000;
        fail_count++;
        test_done();
    end
endmodule
`default_nettype wire
